/* include/crc_params.svh */
// Constants of the reset, interrupt and bus control sequencer
`ifndef CRC_PARAMS_SVH
`define CRC_PARAMS_SVH
// Register offsets (byte addresses)
`define CRC_OFF_CTRL 4'h0
`define CRC_OFF_MASK 4'h4
`define CRC_OFF_VBASE 4'h8
`define CRC_OFF_STAT 4'hc
// Mask register field positions
`define CRC_MB_GEN 0
`define CRC_MB_C 1
`define CRC_MB_B 2
`define CRC_MB_A 3
`define CRC_MASK_RST 4'h1
// Control register bits (write one to pulse; bits 5:4 hold the mode)
`define CRC_CB_EI 0
`define CRC_CB_DI 1
`define CRC_CB_RETURN_FROM_NONMASKABLE 2
`define CRC_CB_IM_LO 4
`define CRC_CB_IM_HI 5
`define CRC_CB_EOI 8
`define CRC_CB_EOM 9
`define CRC_CB_PCLD 10
// Vector locations
`define CRC_VEC_NMI 16'h0066
`define CRC_VEC_A 16'h003c
`define CRC_VEC_B 16'h0034
`define CRC_VEC_C 16'h002c
`define CRC_VEC_GEN 16'h0038
`define CRC_PC_RST 16'h0000
// Timing: T-state is half the oscillator; least reset hold in T-states
`define CRC_RST_T 3
`define CRC_ACK_WAITS 2
`endif

/* include/crc_pkg.sv */
// Types of the reset, interrupt and bus control sequencer
`default_nettype none
package crc_pkg;
	typedef enum logic [5:0] {
		ST_RUN = 6'h01,
		ST_GRANT = 6'h02,
		ST_SAVE = 6'h04,
		ST_DUMMY = 6'h08,
		ST_PUSH = 6'h10,
		ST_ACK = 6'h20
	} crc_state_t;
	typedef struct packed {
		logic nmi;
		logic a;
		logic b;
		logic c;
		logic gen;
	} crc_req_t;
	typedef enum logic [1:0] {
		IM0 = 2'h0,
		IM1 = 2'h1,
		IM2 = 2'h2
	} crc_mode_t;
endpackage
`default_nettype wire

/* logic/crc_ctrl.sv */
// Reset, power-save, bus grant and interrupt sequencer with AXI4-Lite registers
// Behaviour
// RULE_01 - Outside source holds reset low at least three T-states.
// RULE_02 - Peripheral reset output follows the first synchronised reset level.
// RULE_03 - Reset clears program counter to zero.
// RULE_04 - Reset clears vector base and refresh counter.
// RULE_05 - Reset clears restart masks, sets general request mask.
// RULE_06 - Reset disables maskable interrupts and selects mode 0.
// RULE_07 - During reset buses float and strobes are inactive.
// RULE_08 - Power-save input sampled only at instruction end.
// RULE_09 - Power-save halts internal state, clock output keeps running; here clk_run drops low in ST_SAVE.
// RULE_10 - In power-save address strobe stays high, next address shown.
// RULE_11 - Power-save beats interrupts; none accepted while saving.
// RULE_12 - Bus grant first, then power-save if still requested.
// RULE_13 - Bus request sampled at cycle end; grant floats bus, refresh high.
// RULE_14 - During bus request no acknowledge nor refresh; nonmaskable still latched.
// RULE_15 - Bus request beats interrupts; latched ones served after grant.
// RULE_16 - Nonmaskable request pushes counter and vectors to 0x0066.
// RULE_17 - Enabled restarts A, B, C vector to 3c, 34, 2c.
// RULE_18 - Restart response: dummy fetch without read, then two pushes.
// RULE_19 - Mode 0: acknowledge strobes, two waits on the first one.
// RULE_20 - Mode 1 general request vectors to 0x0038.
// RULE_21 - Mode 2: vector base high byte, device byte low, LSB zero.
// RULE_22 - Priority: nonmaskable, A, B, C, general.
// RULE_23 - Two enable flip-flops; second only stores the first.
// RULE_24 - Maskable accepted only with mask bit and both enables set.
// RULE_25 - Enable instruction delays acceptance one instruction; acceptance clears both.
// RULE_26 - Nonmaskable clears first enable; return copies second back.
// RULE_27 - Requests are active-low levels decided once at instruction end.
//
// The implementer's own choices: the AXI4-Lite register port and the address map.
`timescale 1ns/1ns
`default_nettype none
`include "crc_params.svh"
module crc_ctrl
	import crc_pkg::*;
(
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// AXI4-Lite slave
	input wire logic [3:0] s_awaddr,
	input wire logic s_awvalid,
	output logic s_awready,
	input wire logic [31:0] s_wdata,
	input wire logic [3:0] s_wstrb,
	input wire logic s_wvalid,
	output logic s_wready,
	output logic [1:0] s_bresp,
	output logic s_bvalid,
	input wire logic s_bready,
	input wire logic [3:0] s_araddr,
	input wire logic s_arvalid,
	output logic s_arready,
	output logic [31:0] s_rdata,
	output logic [1:0] s_rresp,
	output logic s_rvalid,
	input wire logic s_rready,
	// Device pins
	input wire logic cpu_reset_n,
	input wire logic power_save_n,
	input wire logic bus_request_n,
	input wire logic nmi_n,
	input wire logic restart_req_a_n,
	input wire logic restart_req_b_n,
	input wire logic restart_req_c_n,
	input wire logic general_irq_n,
	input wire logic [7:0] ack_data,
	input wire logic [15:0] next_addr,
	output logic periph_reset,
	output logic bus_grant_n,
	output logic bus_oe_n,
	output logic refresh_strobe_n,
	output logic addr_latch,
	output logic irq_ack_strobe_n,
	output logic [15:0] pc_out,
	output logic [7:0] refresh_cnt,
	output logic [15:0] addr_out,
	output logic clk_run
);
	// ************************************************
	// Reset synchroniser
	// ************************************************
	logic rst_s1_r, rst_s2_r;
	// First stage feeds only the second
	always_ff @(posedge aclk) begin
		rst_s1_r <= ~cpu_reset_n;
		rst_s2_r <= rst_s1_r;
	end
	wire rst = ~aresetn | rst_s2_r;
	// Peripheral reset flop samples the pin itself, so it moves on the first edge
	always_ff @(posedge aclk) begin
		periph_reset <= ~cpu_reset_n; // RULE_02
	end
	// ************************************************
	// Register state
	// ************************************************
	logic [3:0] mask_r;
	logic [7:0] vbase_r;
	crc_mode_t mode_r;
	logic irq_enable_ff_r, irq_enable_shadow_r, ei_hold_r;
	logic [15:0] pc_r;
	logic eoi_r, eom_r; // Instruction end / machine cycle end pulses
	logic [15:0] pc_ld_r;
	crc_state_t st_r;
	logic [2:0] cnt_r;
	logic nmi_lat_r;
	// AXI write channel capture
	logic aw_r, w_r;
	logic [3:0] awaddr_r;
	logic [31:0] wdata_r;
	wire wr_go = aw_r & w_r & ~s_bvalid;
	wire wr_ctrl = wr_go & (awaddr_r == `CRC_OFF_CTRL);
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_r <= 1'b0;
			w_r <= 1'b0;
			awaddr_r <= 4'h0;
			wdata_r <= 32'h0;
			s_bvalid <= 1'b0;
		end else begin
			if (s_awvalid && s_awready) begin
				aw_r <= 1'b1;
				awaddr_r <= s_awaddr;
			end
			if (s_wvalid && s_wready) begin
				w_r <= 1'b1;
				wdata_r <= s_wdata;
			end
			if (wr_go) begin
				aw_r <= 1'b0;
				w_r <= 1'b0;
				s_bvalid <= 1'b1;
			end else if (s_bready) begin
				s_bvalid <= 1'b0;
			end
		end
	end
	assign s_awready = ~aw_r & aresetn;
	assign s_wready = ~w_r & aresetn;
	assign s_bresp = (awaddr_r[1:0] != 2'h0) ? 2'h2 : 2'h0;
	// Control pulses decoded from control register writes
	wire p_ei = wr_ctrl & wdata_r[`CRC_CB_EI];
	wire p_di = wr_ctrl & wdata_r[`CRC_CB_DI];
	wire p_return_from_nonmaskable = wr_ctrl & wdata_r[`CRC_CB_RETURN_FROM_NONMASKABLE];
	always_ff @(posedge aclk) begin
		eoi_r <= wr_ctrl & wdata_r[`CRC_CB_EOI];
		eom_r <= wr_ctrl & (wdata_r[`CRC_CB_EOM] | wdata_r[`CRC_CB_EOI]);
	end
	// ************************************************
	// Request decision
	// ************************************************
	crc_req_t req;
	assign req.nmi = nmi_lat_r;
	assign req.a = ~restart_req_a_n & mask_r[`CRC_MB_A]; // RULE_27
	assign req.b = ~restart_req_b_n & mask_r[`CRC_MB_B];
	assign req.c = ~restart_req_c_n & mask_r[`CRC_MB_C];
	assign req.gen = ~general_irq_n & mask_r[`CRC_MB_GEN];
	wire ien = irq_enable_ff_r & irq_enable_shadow_r & ~ei_hold_r; // RULE_24 RULE_25
	wire mask_any = ien & (req.a | req.b | req.c | req.gen);
	wire take = eoi_r & (st_r == ST_RUN) & bus_request_n & power_save_n; // RULE_11 RULE_15
	wire take_nmi = take & req.nmi;
	wire take_mask = take & ~req.nmi & mask_any;
	logic [15:0] vec;
	// Fixed priority vector selection
	always_comb begin
		vec = `CRC_VEC_GEN; // RULE_20
		if (req.nmi) vec = `CRC_VEC_NMI; // RULE_22 RULE_16
		else if (req.a) vec = `CRC_VEC_A; // RULE_17
		else if (req.b) vec = `CRC_VEC_B;
		else if (req.c) vec = `CRC_VEC_C;
	end
	wire gen_only = ~req.nmi & ~req.a & ~req.b & ~req.c;
	// Nonmaskable latch, kept during bus grant
	always_ff @(posedge aclk) begin
		if (rst) nmi_lat_r <= 1'b0;
		else if (~nmi_n) nmi_lat_r <= 1'b1; // RULE_14
		else if (take_nmi) nmi_lat_r <= 1'b0;
	end
	// ************************************************
	// Mask, base and mode registers
	// ************************************************
	always_ff @(posedge aclk) begin
		if (rst) begin
			mask_r <= `CRC_MASK_RST; // RULE_05
			vbase_r <= 8'h00; // RULE_04
			mode_r <= IM0; // RULE_06
		end else if (wr_go && awaddr_r == `CRC_OFF_MASK && s_wstrb[0]) begin
			mask_r <= wdata_r[3:0];
		end else if (wr_go && awaddr_r == `CRC_OFF_VBASE && s_wstrb[0]) begin
			vbase_r <= wdata_r[7:0];
		end else if (wr_ctrl && wdata_r[`CRC_CB_IM_HI:`CRC_CB_IM_LO] != 2'h3) begin
			mode_r <= crc_mode_t'(wdata_r[`CRC_CB_IM_HI:`CRC_CB_IM_LO]);
		end
	end
	// Enable flip-flops
	always_ff @(posedge aclk) begin
		if (rst) begin
			irq_enable_ff_r <= 1'b0; // RULE_06
			irq_enable_shadow_r <= 1'b0;
			ei_hold_r <= 1'b0;
		end else if (take_nmi) begin
			irq_enable_ff_r <= 1'b0; // RULE_26
		end else if (take_mask) begin
			irq_enable_ff_r <= 1'b0; // RULE_25
			irq_enable_shadow_r <= 1'b0;
		end else if (p_ei) begin
			irq_enable_ff_r <= 1'b1; // RULE_23
			irq_enable_shadow_r <= 1'b1;
			ei_hold_r <= 1'b1;
		end else if (p_di) begin
			irq_enable_ff_r <= 1'b0;
			irq_enable_shadow_r <= 1'b0;
		end else if (p_return_from_nonmaskable) begin
			irq_enable_ff_r <= irq_enable_shadow_r; // RULE_26
		end else if (eoi_r) begin
			ei_hold_r <= 1'b0; // RULE_25
		end
	end
	// ************************************************
	// Sequencer
	// ************************************************
	always_ff @(posedge aclk) begin
		if (rst) begin
			st_r <= ST_RUN;
			cnt_r <= 3'h0;
			pc_r <= `CRC_PC_RST; // RULE_03
			refresh_cnt <= 8'h00; // RULE_04
			irq_ack_strobe_n <= 1'b1;
			pc_ld_r <= 16'h0;
		end else begin
			case (st_r)
				ST_RUN: begin
					if (wr_ctrl && wdata_r[`CRC_CB_PCLD]) pc_r <= wdata_r[31:16];
					if (eom_r && bus_request_n) refresh_cnt <= refresh_cnt + 8'h01; // RULE_14
					if (eom_r && !bus_request_n) begin
						st_r <= ST_GRANT; // RULE_13 RULE_12
					end else if (eoi_r && !power_save_n) begin
						st_r <= ST_SAVE; // RULE_08 RULE_11
					end else if (take_nmi || (take_mask && !gen_only) ||
						(take_mask && mode_r == IM1)) begin
						st_r <= ST_DUMMY; // RULE_18
						pc_ld_r <= vec;
						cnt_r <= 3'h0;
					end else if (take_mask) begin
						st_r <= ST_ACK; // RULE_19 RULE_21
						irq_ack_strobe_n <= 1'b0;
						cnt_r <= 3'h0;
					end
				end
				ST_GRANT: begin
					if (bus_request_n) st_r <= power_save_n ? ST_RUN : ST_SAVE; // RULE_12
				end
				ST_SAVE: begin
					if (power_save_n) st_r <= ST_RUN; // RULE_09
				end
				ST_DUMMY: begin
					st_r <= ST_PUSH;
					cnt_r <= 3'h0;
				end
				ST_PUSH: begin
					cnt_r <= cnt_r + 3'h1;
					if (cnt_r == 3'h1) begin
						st_r <= ST_RUN;
						pc_r <= pc_ld_r;
					end
				end
				ST_ACK: begin
					cnt_r <= cnt_r + 3'h1;
					if (mode_r == IM2) begin
						// Pointer from base and device byte, LSB forced low
						pc_ld_r <= {vbase_r, ack_data[7:1], 1'b0}; // RULE_21
						irq_ack_strobe_n <= 1'b1;
						st_r <= ST_PUSH;
						cnt_r <= 3'h0;
					end else if (cnt_r == 3'(`CRC_ACK_WAITS)) begin
						irq_ack_strobe_n <= 1'b1; // RULE_19
						st_r <= ST_RUN;
					end
				end
				default: st_r <= ST_RUN;
			endcase
		end
	end
	// ************************************************
	// Pin outputs
	// ************************************************
	always_ff @(posedge aclk) begin
		if (rst) begin
			bus_oe_n <= 1'b1; // RULE_07
			bus_grant_n <= 1'b1;
			refresh_strobe_n <= 1'b1;
			addr_latch <= 1'b0;
			clk_run <= 1'b1;
			addr_out <= 16'h0;
			pc_out <= 16'h0;
		end else begin
			bus_grant_n <= ~(st_r == ST_GRANT);
			bus_oe_n <= (st_r == ST_GRANT); // RULE_13
			refresh_strobe_n <= ~(eom_r & bus_request_n & (st_r == ST_RUN));
			addr_latch <= (st_r == ST_SAVE); // RULE_10
			clk_run <= (st_r != ST_SAVE); // RULE_09
			addr_out <= (st_r == ST_SAVE) ? next_addr : pc_r;
			pc_out <= pc_r;
		end
	end
	// ************************************************
	// AXI read channel
	// ************************************************
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_rvalid <= 1'b0;
			s_rdata <= 32'h0;
			s_rresp <= 2'h0;
		end else if (s_arvalid && s_arready) begin
			s_rvalid <= 1'b1;
			s_rresp <= 2'h0;
			case (s_araddr)
				`CRC_OFF_CTRL: s_rdata <= {26'h0, mode_r, 4'h0};
				`CRC_OFF_MASK: s_rdata <= 32'h0; // Write only
				`CRC_OFF_VBASE: s_rdata <= {24'h0, vbase_r};
				`CRC_OFF_STAT: s_rdata <= {pc_r, refresh_cnt, 2'h0, st_r[5:0]} |
					{29'h0, nmi_lat_r, irq_enable_shadow_r, irq_enable_ff_r} << 0;
				default: begin
					s_rdata <= 32'h0;
					s_rresp <= 2'h2;
				end
			endcase
		end else if (s_rready) begin
			s_rvalid <= 1'b0;
		end
	end
	assign s_arready = ~s_rvalid & aresetn;
	// ************************************************
	// Checks
	// ************************************************
	property p_rst_vals;
		@(posedge aclk) disable iff (!aresetn) rst_s2_r |=> (pc_r == 16'h0 && mask_r == 4'h1);
	endproperty
	a_rst_vals: assert property (p_rst_vals) else $error("reset values wrong"); // RULE_05
	property p_nmi_vec;
		@(posedge aclk) disable iff (rst) take_nmi |=> ##3 pc_r == 16'h0066;
	endproperty
	a_nmi_vec: assert property (p_nmi_vec) else $error("nmi vector wrong"); // RULE_16
	property p_iff_nmi;
		@(posedge aclk) disable iff (rst) take_nmi |=> !irq_enable_ff_r && irq_enable_shadow_r == $past(irq_enable_shadow_r);
	endproperty
	a_iff_nmi: assert property (p_iff_nmi) else $error("nmi enable handling wrong"); // RULE_26
	property p_grant_float;
		@(posedge aclk) disable iff (rst) st_r == ST_GRANT |=> bus_oe_n && refresh_strobe_n;
	endproperty
	a_grant_float: assert property (p_grant_float) else $error("grant bus not floated"); // RULE_13
	property p_save_ale;
		@(posedge aclk) disable iff (rst) st_r == ST_SAVE |=> addr_latch && !clk_run;
	endproperty
	a_save_ale: assert property (p_save_ale) else $error("save strobe wrong"); // RULE_10
	property p_no_take_save;
		@(posedge aclk) disable iff (rst) eoi_r && st_r == ST_RUN && bus_request_n &&
			!power_save_n |=> st_r == ST_SAVE;
	endproperty
	a_no_take_save: assert property (p_no_take_save) else $error("power-save lost to interrupt"); // RULE_11
	property p_mask_gate;
		@(posedge aclk) disable iff (rst) take_mask |-> irq_enable_ff_r && irq_enable_shadow_r;
	endproperty
	a_mask_gate: assert property (p_mask_gate) else $error("masked request taken"); // RULE_24
	property p_mask_clear;
		@(posedge aclk) disable iff (rst) take_mask |=> !irq_enable_ff_r && !irq_enable_shadow_r;
	endproperty
	a_mask_clear: assert property (p_mask_clear) else $error("enables not cleared"); // RULE_25
endmodule
`default_nettype wire

/* verif/crc_far_model.sv */
// Far-side model: reset source, interrupt sources, bus master and acknowledge data
`timescale 1ns/1ns
`default_nettype none
module crc_far_model
	import crc_pkg::*;
#(
	parameter logic [15:0] NEXT_ADDR = 16'h4a21
)
(
	// Clock and bench commands
	input wire logic aclk,
	input wire logic want_reset,
	input wire crc_req_t want_req,
	input wire logic want_bus,
	input wire logic want_save,
	input wire logic [7:0] vec_byte,
	// Acknowledge strobe from the device
	input wire logic irq_ack_strobe_n,
	// Lines into the device
	output logic cpu_reset_n,
	output logic power_save_n,
	output logic bus_request_n,
	output logic nmi_n,
	output logic restart_req_a_n,
	output logic restart_req_b_n,
	output logic restart_req_c_n,
	output logic general_irq_n,
	output logic [7:0] ack_data,
	output logic [15:0] next_addr
);
	// ****************************************
	// Stimulus lines
	// ****************************************
	logic [1:0] hold_r;
	logic nmi_was_r;
	// Reset held low, all other lines at quiet levels before the first edge
	initial begin
		hold_r = 2'h0;
		nmi_was_r = 1'b0;
		cpu_reset_n = 1'b0;
		{power_save_n, bus_request_n, nmi_n} = 3'h7;
		{restart_req_a_n, restart_req_b_n, restart_req_c_n, general_irq_n} = 4'hf;
	end
	assign next_addr = NEXT_ADDR;
	// Reset source keeps the line low some T-states past the last request
	always @(posedge aclk) begin
		if (want_reset)
			hold_r <= 2'h2;
		else if (hold_r != 2'h0)
			hold_r <= hold_r - 2'h1;
		cpu_reset_n <= !(want_reset || hold_r != 2'h0);
	end
	// Level requests; the nonmaskable one is a one-cycle pulse
	always @(posedge aclk) begin
		nmi_was_r <= want_req.nmi;
		nmi_n <= !(want_req.nmi && !nmi_was_r);
		restart_req_a_n <= !want_req.a;
		restart_req_b_n <= !want_req.b;
		restart_req_c_n <= !want_req.c;
		general_irq_n <= !want_req.gen;
		bus_request_n <= !want_bus;
		power_save_n <= !want_save;
	end
	// Device gates its byte while the strobe is low; a released path shows the inverse
	assign ack_data = (irq_ack_strobe_n == 1'b0) ? vec_byte : ~vec_byte;
endmodule
`default_nettype wire

/* verif/tb_top.sv */
// Self-checking bench of the reset, interrupt and bus control sequencer
`timescale 1ns/1ns
`default_nettype none
`include "crc_params.svh"
module tb_top import crc_pkg::*;;
	// ****************************************
	// Signals and instances
	// ****************************************
	logic aclk, aresetn, s_awvalid, s_wvalid, s_bready, s_arvalid, s_rready;
	logic s_awready, s_wready, s_bvalid, s_arready, s_rvalid;
	logic [3:0] s_awaddr, s_araddr;
	logic [31:0] s_wdata, s_rdata, rd;
	logic [1:0] s_bresp, s_rresp, rsp;
	logic want_reset, want_bus, want_save;
	crc_req_t want_req;
	logic [7:0] vec_byte, ack_data, refresh_cnt;
	logic cpu_reset_n, power_save_n, bus_request_n, nmi_n, general_irq_n;
	logic restart_req_a_n, restart_req_b_n, restart_req_c_n;
	logic periph_reset, bus_grant_n, bus_oe_n, refresh_strobe_n, addr_latch;
	logic irq_ack_strobe_n, clk_run;
	logic [15:0] next_addr, pc_out, addr_out, pc_keep;
	logic [15:0] vec [5];
	int bad_count, total_checks, ack_cnt, ref_cnt;
	crc_ctrl dut_u (.aclk, .aresetn, .s_awaddr, .s_awvalid, .s_awready, .s_wdata,
		.s_wstrb(4'hf), .s_wvalid, .s_wready, .s_bresp, .s_bvalid, .s_bready, .s_araddr,
		.s_arvalid, .s_arready, .s_rdata, .s_rresp, .s_rvalid, .s_rready, .cpu_reset_n,
		.power_save_n, .bus_request_n, .nmi_n, .restart_req_a_n, .restart_req_b_n,
		.restart_req_c_n, .general_irq_n, .ack_data, .next_addr, .periph_reset,
		.bus_grant_n, .bus_oe_n, .refresh_strobe_n, .addr_latch, .irq_ack_strobe_n,
		.pc_out, .refresh_cnt, .addr_out, .clk_run);
	crc_far_model far_u (.aclk, .want_reset, .want_req, .want_bus, .want_save, .vec_byte,
		.irq_ack_strobe_n, .cpu_reset_n, .power_save_n, .bus_request_n, .nmi_n,
		.restart_req_a_n, .restart_req_b_n, .restart_req_c_n, .general_irq_n, .ack_data,
		.next_addr);
	// Clock at 40 ns period
	initial begin
		aclk = 1'b0;
		forever #20 aclk = ~aclk;
	end
	// Strobe cycle counters
	always @(posedge aclk) begin
		if (irq_ack_strobe_n === 1'b0) ack_cnt++;
		if (refresh_strobe_n === 1'b0) ref_cnt++;
	end
	// ****************************************
	// Tasks
	// ****************************************
	task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
		total_checks++;
		if (seen !== exp) begin
			bad_count++;
			$display("unexpected %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", total_checks, bad_count);
		if (bad_count == 0 && total_checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	task automatic give_up(input string nm);
		chk(nm, 16'h0, 16'h1);
		tally_and_finish();
	endtask
	task automatic wait_lvl(input string nm, ref logic s, input logic v);
		for (int n = 0; n < 200 && s !== v; n++) @(posedge aclk);
		if (s !== v) give_up(nm);
	endtask
	task automatic wait_pc(input logic [15:0] v);
		for (int n = 0; n < 200 && pc_out !== v; n++) @(posedge aclk);
		chk("pc_out", pc_out, v);
	endtask
	// Write one word; address and data offered together, bready held for the answer
	task automatic axi_wr(input logic [3:0] a, input logic [31:0] d);
		int n;
		n = 0;
		s_awaddr <= a;
		s_wdata <= d;
		{s_awvalid, s_wvalid, s_bready} <= 3'h7;
		do begin
			@(posedge aclk);
			n++;
			if (s_awready === 1'b1) s_awvalid <= 1'b0;
			if (s_wready === 1'b1) s_wvalid <= 1'b0;
		end while (s_bvalid !== 1'b1 && n < 50);
		rsp = s_bresp;
		if (s_bvalid !== 1'b1) give_up("bvalid");
	endtask
	task automatic axi_rd(input logic [3:0] a);
		int n;
		n = 0;
		s_araddr <= a;
		{s_arvalid, s_rready} <= 2'h3;
		do begin
			@(posedge aclk);
			n++;
			if (s_arready === 1'b1) s_arvalid <= 1'b0;
		end while (s_rvalid !== 1'b1 && n < 50);
		rd = s_rdata;
		rsp = s_rresp;
		if (s_rvalid !== 1'b1) give_up("rvalid");
	endtask
	// Control pulses keep the mode field at the ignored value
	task automatic ctl(input logic [31:0] d);
		axi_wr(`CRC_OFF_CTRL, d | 32'h30);
	endtask
	task automatic arm();
		want_req <= '0;
		ctl(32'h1);
		ctl(32'h100);
	endtask
	// ****************************************
	// Main sequence
	// ****************************************
	initial begin
		{aresetn, s_awvalid, s_wvalid, s_bready, s_arvalid, s_rready} = '0;
		{s_awaddr, s_araddr, s_wdata, want_bus, want_save} = '0;
		{bad_count, total_checks, ack_cnt, ref_cnt} = '0;
		want_reset = 1'b1;
		want_req = '0;
		vec_byte = 8'h35;
		vec = '{`CRC_VEC_NMI, `CRC_VEC_A, `CRC_VEC_B, `CRC_VEC_C, `CRC_VEC_GEN};
		repeat (4) @(posedge aclk);
		aresetn <= 1'b1;
		wait_lvl("periph_reset", periph_reset, 1'b1);
		chk("bus_oe_n", {15'h0, bus_oe_n}, 16'h1);
		chk("strobes", {14'h0, refresh_strobe_n, irq_ack_strobe_n}, 16'h3);
		want_reset <= 1'b0;
		wait_lvl("periph_reset", periph_reset, 1'b0);
		chk("pc_out", pc_out, `CRC_PC_RST);
		chk("refresh_cnt", {8'h0, refresh_cnt}, 16'h0);
		axi_rd(`CRC_OFF_CTRL);
		chk("mode", {14'h0, rd[5:4]}, 16'h0);
		axi_rd(`CRC_OFF_VBASE);
		chk("vbase", rd[15:0], 16'h0);
		axi_wr(4'h2, 32'h0);
		chk("bresp", {14'h0, rsp}, 16'h2);
		axi_rd(4'h2);
		chk("rresp", {14'h0, rsp}, 16'h2);
		chk("rdata", rd[15:0], 16'h0);
		// Restart A and general request, enables still off after reset
		axi_wr(`CRC_OFF_CTRL, 32'h10);
		want_req <= crc_req_t'(5'h09);
		ctl(32'h100);
		repeat (20) @(posedge aclk);
		chk("pc_out", pc_out, `CRC_PC_RST);
		arm();
		want_req <= crc_req_t'(5'h09);
		ctl(32'h100);
		wait_pc(`CRC_VEC_GEN);
		ctl(32'h100);
		repeat (20) @(posedge aclk);
		chk("pc_out", pc_out, `CRC_VEC_GEN);
		// Enable then disable: the pending general request must stay unserved
		ctl(32'h1);
		ctl(32'h2);
		ctl(32'h100);
		ctl(32'h100);
		repeat (10) @(posedge aclk);
		chk("pc_out", pc_out, `CRC_VEC_GEN);
		// All sources at once, the winner withdrawn each round
		axi_wr(`CRC_OFF_MASK, 32'hf);
		for (int i = 0; i < 5; i++) begin
			arm();
			want_req <= crc_req_t'(5'h1f >> i);
			ctl(32'h100);
			wait_pc(vec[i]);
		end
		// Nonmaskable over a pending general request, then return restores the enable
		ctl(32'h400);
		arm();
		want_req <= crc_req_t'(5'h11);
		ctl(32'h100);
		wait_pc(`CRC_VEC_NMI);
		ctl(32'h4);
		ctl(32'h100);
		wait_pc(`CRC_VEC_GEN);
		// Acknowledge strobes in modes 0 and 2
		axi_wr(`CRC_OFF_VBASE, 32'h12);
		for (int m = 0; m < 4; m += 2) begin
			axi_wr(`CRC_OFF_CTRL, {26'h0, m[1:0], 4'h0});
			arm();
			ack_cnt = 0;
			want_req <= crc_req_t'(5'h01);
			ctl(32'h100);
			repeat (30) @(posedge aclk);
			chk("ack_cycles", ack_cnt[15:0], m == 0 ? 16'h3 : 16'h1);
			chk("ack_seen", {15'h0, ack_cnt != 0}, 16'h1);
		end
		chk("pc_out", pc_out, {8'h12, 8'h35 & 8'hfe});
		want_req <= '0;
		// Bus grant: floated bus, no refresh, nonmaskable latched meanwhile
		want_bus <= 1'b1;
		ctl(32'h200);
		wait_lvl("bus_grant_n", bus_grant_n, 1'b0);
		chk("grant_lines", {14'h0, bus_oe_n, refresh_strobe_n}, 16'h3);
		pc_keep = pc_out;
		ref_cnt = 0;
		want_req <= crc_req_t'(5'h10);
		ctl(32'h200);
		ctl(32'h100);
		repeat (10) @(posedge aclk);
		chk("pc_out", pc_out, pc_keep);
		chk("refresh_cycles", ref_cnt[15:0], 16'h0);
		want_bus <= 1'b0;
		want_req <= '0;
		wait_lvl("bus_grant_n", bus_grant_n, 1'b1);
		ctl(32'h100);
		wait_pc(`CRC_VEC_NMI);
		// Power-save only at instruction end
		want_save <= 1'b1;
		ctl(32'h200);
		repeat (10) @(posedge aclk);
		chk("clk_run", {15'h0, clk_run}, 16'h1);
		ctl(32'h100);
		wait_lvl("clk_run", clk_run, 1'b0);
		chk("addr_latch", {15'h0, addr_latch}, 16'h1);
		chk("addr_out", addr_out, next_addr);
		want_save <= 1'b0;
		wait_lvl("clk_run", clk_run, 1'b1);
		// Bus grant served before power-save
		{want_bus, want_save} <= 2'h3;
		ctl(32'h100);
		wait_lvl("bus_grant_n", bus_grant_n, 1'b0);
		chk("clk_run", {15'h0, clk_run}, 16'h1);
		want_bus <= 1'b0;
		wait_lvl("clk_run", clk_run, 1'b0);
		want_save <= 1'b0;
		wait_lvl("clk_run", clk_run, 1'b1);
		tally_and_finish();
	end
endmodule
`default_nettype wire
